// file: verilog/sleep_entry_defs.vh
// Constants for the sleep entry block of the SDRAM controller.
// Assumes inclusion by bare name from the design files.
`ifndef SLEEP_ENTRY_DEFS_VH
`define SLEEP_ENTRY_DEFS_VH
// ---------------------------------------------------------------
// Refresh control field positions
// ---------------------------------------------------------------
`define REFR_SELF_BIT      31
`define REFR_CKE_BIT       20
`define REFR_INTERVAL_HI   15
`define REFR_INTERVAL_LO   4
`define REFR_RESET         32'h0010_0000
// ---------------------------------------------------------------
// Configuration bank enables and the PMC sleep bit
// ---------------------------------------------------------------
`define CFG_BANK_MASK      32'h0003_0003
`define CFG_RESET          32'h0000_0000
`define PMC_SLEEP_BIT      0
// ---------------------------------------------------------------
// SDRAM commands {cs_n, ras_n, cas_n, we_n}
// ---------------------------------------------------------------
`define CMD_NOP            4'h7
`define CMD_PRECHARGE      4'h2
`define CMD_AUTO_REFRESH   4'h1
`define CMD_SELF_REFRESH   4'h1
// ---------------------------------------------------------------
// Timing, in ns and derived cycles at 20 ns
// ---------------------------------------------------------------
`define CLK_PERIOD_NS      20
`define T_RP_NS            20
`define T_RP_CYC           ((`T_RP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_RFC_NS           80
`define T_RFC_CYC          ((`T_RFC_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WAIT_W             4
`endif

// file: verilog/wait_timer.v
// Small down counter for SDRAM command spacing.
// Assumes one clock and synchronous active low reset.
`timescale 1ns/1ns
`include "sleep_entry_defs.vh"
module wait_timer (
   input  wire                 mclk_i,
   input  wire                 rst_n_i,
   input  wire                 load_i,
   input  wire [`WAIT_W-1:0]   count_i,
   output wire                 done_o
);
   reg [`WAIT_W-1:0] remain;
   assign done_o = (remain == {`WAIT_W{1'b0}});
   always @(posedge mclk_i) begin
      if (!rst_n_i) begin
         remain <= {`WAIT_W{1'b0}};
      end else if (load_i) begin
         remain <= count_i;
      end else if (!done_o) begin
         remain <= remain - {{(`WAIT_W-1){1'b0}}, 1'b1};
      end
   end
endmodule

// file: verilog/sdram_sleep_self_refresh_entry.v
// Sleep entry sequencer: register writes, precharge, self-refresh.
// Assumes register writes arrive as one-cycle strobes on mclk_i and
// fault pins are asynchronous to it.
`timescale 1ns/1ns
`include "sleep_entry_defs.vh"
module sdram_sleep_self_refresh_entry (
   input  wire        mclk_i,
   input  wire        rst_n_i,
   input  wire        refr_wr_i,
   input  wire [31:0] refr_wdata_i,
   input  wire        cfg_wr_i,
   input  wire [31:0] cfg_wdata_i,
   input  wire        pmc_wr_i,
   input  wire [31:0] pmc_wdata_i,
   input  wire        row_open_i,
   input  wire        burst_busy_i,
   input  wire        battery_fault_input_i,
   input  wire        supply_fault_i,
   output reg         wr_ready_o,
   output reg  [31:0] refr_o,
   output reg  [31:0] cfg_o,
   output reg  [3:0]  sdram_cmd_o,
   output reg         sdram_cke_o,
   output reg         self_refresh_o,
   output reg         sleep_o
);
   // ---------------------------------------------------------------
   // States
   // ---------------------------------------------------------------
   localparam ST_IDLE   = 3'h0;
   localparam ST_PRE    = 3'h1;
   localparam ST_PREW   = 3'h2;
   localparam ST_SREF   = 3'h3;
   localparam ST_SLEEPR = 3'h4;
   localparam ST_EXIT   = 3'h5;
   localparam ST_SLEEP  = 3'h6;

   // Timer loads, cut to the counter width on purpose
   localparam [31:0] RP_WAIT  = `T_RP_CYC;
   localparam [31:0] RFC_WAIT = `T_RFC_CYC;

   reg  [2:0]  state;
   reg  [2:0]  next_state;
   reg  [1:0]  batt_sync;
   reg  [1:0]  vdd_sync;
   reg         sleep_req;
   reg         pend_refr;
   reg  [31:0] pend_data;
   reg         tmr_load;
   reg  [`WAIT_W-1:0] tmr_count;
   wire        tmr_done;
   wire        fault;
   wire        self_set;
   wire        self_clr;

   wait_timer u_wait (
      .mclk_i  (mclk_i),
      .rst_n_i (rst_n_i),
      .load_i  (tmr_load),
      .count_i (tmr_count),
      .done_o  (tmr_done)
   );

   // ---------------------------------------------------------------
   // Fault synchronisers
   // ---------------------------------------------------------------
   always @(posedge mclk_i) begin
      if (!rst_n_i) begin
         batt_sync <= 2'h0;
         vdd_sync  <= 2'h0;
      end else begin
         batt_sync <= {batt_sync[0], battery_fault_input_i};
         vdd_sync  <= {vdd_sync[0], supply_fault_i};
      end
   end
   assign fault = batt_sync[1] | vdd_sync[1];

   // ---------------------------------------------------------------
   // Register write path
   // ---------------------------------------------------------------
   // Refresh writes that set self-refresh are held until the
   // self-refresh command they trigger has been issued; others apply in idle.
   assign self_set = pend_refr & pend_data[`REFR_SELF_BIT] &
                     ~refr_o[`REFR_SELF_BIT];
   assign self_clr = pend_refr & ~pend_data[`REFR_SELF_BIT] &
                     refr_o[`REFR_SELF_BIT];

   always @(posedge mclk_i) begin
      if (!rst_n_i) begin
         refr_o     <= `REFR_RESET;
         cfg_o      <= `CFG_RESET;
         pend_refr  <= 1'b0;
         pend_data  <= 32'h0000_0000;
         wr_ready_o <= 1'b1;
         sleep_req  <= 1'b0;
      end else begin
         if (refr_wr_i && wr_ready_o) begin
            pend_refr  <= 1'b1;
            pend_data  <= refr_wdata_i;
            wr_ready_o <= 1'b0;
         end else if (pend_refr && state == ST_IDLE && !self_set &&
                      !self_clr) begin
            refr_o     <= pend_data;
            pend_refr  <= 1'b0;
            wr_ready_o <= 1'b1;
         end else if (pend_refr && (state == ST_SLEEPR) &&
                      self_set) begin
            refr_o     <= pend_data;
            pend_refr  <= 1'b0;
            wr_ready_o <= 1'b1;
         end else if (pend_refr && state == ST_IDLE && self_clr) begin
            refr_o     <= pend_data;
            pend_refr  <= 1'b0;
            wr_ready_o <= 1'b1;
         end
         if (cfg_wr_i && wr_ready_o) begin
            cfg_o <= cfg_wdata_i;
         end
         if (pmc_wr_i && wr_ready_o && pmc_wdata_i[`PMC_SLEEP_BIT]) begin
            sleep_req <= 1'b1;
         end else if (fault) begin
            sleep_req <= 1'b1;
         end else if (state == ST_SLEEP && !fault) begin
            sleep_req <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // Command sequencer
   // ---------------------------------------------------------------
   always @* begin
      next_state = state;
      tmr_load   = 1'b0;
      tmr_count  = {`WAIT_W{1'b0}};
      case (state)
         ST_IDLE: begin
            if ((self_set || (sleep_req && !self_refresh_o)) &&
                !burst_busy_i) begin
               next_state = ST_PRE;
            end else if (sleep_req && self_refresh_o) begin
               next_state = ST_SLEEP;
            end
         end
         ST_PRE: begin
            if (row_open_i) begin
               tmr_load   = 1'b1;
               tmr_count  = RP_WAIT[`WAIT_W-1:0];
               next_state = ST_PREW;
            end else begin
               next_state = ST_SREF;
            end
         end
         ST_PREW: begin
            if (tmr_done) begin
               next_state = ST_PRE;
            end
         end
         ST_SREF: begin
            tmr_load   = 1'b1;
            tmr_count  = RFC_WAIT[`WAIT_W-1:0];
            next_state = ST_SLEEPR;
         end
         ST_SLEEPR: begin
            // Only a write setting self-refresh applies here, others wait for idle; waiting
            // on them here as well would deadlock the sequencer.
            if (tmr_done) begin
               next_state = sleep_req ? ST_SLEEP : ST_IDLE;
            end
         end
         ST_SLEEP: begin
            if (!sleep_req) begin
               next_state = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   always @(posedge mclk_i) begin
      if (!rst_n_i) begin
         state          <= ST_IDLE;
         sdram_cmd_o    <= `CMD_NOP;
         sdram_cke_o    <= 1'b1;
         self_refresh_o <= 1'b0;
         sleep_o        <= 1'b0;
      end else begin
         state       <= next_state;
         sdram_cmd_o <= `CMD_NOP;
         if (state == ST_PRE && row_open_i) begin
            sdram_cmd_o <= `CMD_PRECHARGE;
         end
         if (state == ST_SREF && !row_open_i) begin
            sdram_cmd_o    <= `CMD_SELF_REFRESH;
            sdram_cke_o    <= 1'b0;
            self_refresh_o <= 1'b1;
         end
         // Clearing the request with the clock enable cleared keeps
         // the devices in self-refresh across sleep.
         if (state == ST_IDLE && self_clr) begin
            self_refresh_o <= ~pend_data[`REFR_CKE_BIT] & self_refresh_o;
            sdram_cke_o    <= pend_data[`REFR_CKE_BIT];
         end
         sleep_o <= (next_state == ST_SLEEP);
      end
   end
endmodule

// file: test/sdram_row_model.sv
// SDRAM row and burst state as seen at the controller pins.
// Assumes the bench pulses open_req_i to start one burst.
`timescale 1ns/1ns
module sdram_row_model (
   input  wire       mclk_i,
   input  wire       rst_n_i,
   input  wire       open_req_i,
   input  wire [3:0] sdram_cmd_i,
   output logic      row_open_o,
   output logic      burst_busy_o
);
   logic [1:0] beats;
   // Row stays open until a precharge, as a real part does
   always @(posedge mclk_i) begin
      if (!rst_n_i || sdram_cmd_i == 4'h2) begin
         row_open_o <= 1'b0;
      end else if (open_req_i) begin
         row_open_o <= 1'b1;
      end
      if (!rst_n_i) begin
         beats <= 2'h0;
      end else if (open_req_i) begin
         beats <= 2'h3;
      end else if (beats != 2'h0) begin
         beats <= beats - 2'h1;
      end
   end
   assign burst_busy_o = (beats != 2'h0);
endmodule

// file: test/sdram_sleep_self_refresh_entry_props.sv
// Checker for the sleep entry sequencer ports.
// Assumes one clock domain and synchronous active low reset.
`timescale 1ns/1ns
module sleep_entry_props (
   input wire        mclk_i,
   input wire        rst_n_i,
   input wire        refr_wr_i,
   input wire [31:0] refr_wdata_i,
   input wire        cfg_wr_i,
   input wire [31:0] cfg_wdata_i,
   input wire        row_open_i,
   input wire        supply_fault_i,
   input wire        wr_ready_o,
   input wire [31:0] refr_o,
   input wire [31:0] cfg_o,
   input wire [3:0]  sdram_cmd_o,
   input wire        sdram_cke_o,
   input wire        self_refresh_o,
   input wire        sleep_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);
   property p_pre_first;
      refr_wr_i && wr_ready_o && refr_wdata_i[31] && !refr_o[31]
         && row_open_i |-> ##[1:6] sdram_cmd_o == 4'h2;
   endproperty
   a_pre_first: assert property (p_pre_first)
      else $error("no precharge before self-refresh");
   property p_no_sr_open;
      sdram_cmd_o == 4'h1 && !sdram_cke_o |-> !row_open_i &&
         !$past(row_open_i);
   endproperty
   a_no_sr_open: assert property (p_no_sr_open)
      else $error("self-refresh with row open");
   property p_cke_drop;
      $fell(sdram_cke_o) |-> sdram_cmd_o == 4'h1;
   endproperty
   a_cke_drop: assert property (p_cke_drop)
      else $error("clock enable fell without self-refresh");
   property p_fault_sleep;
      (self_refresh_o && supply_fault_i) [*2] |-> ##[0:8] sleep_o;
   endproperty
   a_fault_sleep: assert property (p_fault_sleep)
      else $error("fault did not bring sleep");
   property p_busy;
      refr_wr_i && wr_ready_o |=> !wr_ready_o ##[1:30] wr_ready_o;
   endproperty
   a_busy: assert property (p_busy)
      else $error("refresh write handshake wrong");
   property p_refr_plain;
      refr_wr_i && wr_ready_o && refr_wdata_i[31] == refr_o[31]
         |-> ##2 refr_o == $past(refr_wdata_i, 2);
   endproperty
   a_refr_plain: assert property (p_refr_plain)
      else $error("refresh value not applied");
   property p_cfg;
      cfg_wr_i && wr_ready_o |=> cfg_o == $past(cfg_wdata_i);
   endproperty
   a_cfg: assert property (p_cfg)
      else $error("configuration value not applied");
   property p_sleep_sr;
      $rose(sleep_o) |-> self_refresh_o && !sdram_cke_o;
   endproperty
   a_sleep_sr: assert property (p_sleep_sr)
      else $error("sleep without self-refresh");
endmodule
bind sdram_sleep_self_refresh_entry sleep_entry_props u_props (
   .mclk_i(mclk_i), .rst_n_i(rst_n_i), .refr_wr_i(refr_wr_i),
   .refr_wdata_i(refr_wdata_i), .cfg_wr_i(cfg_wr_i),
   .cfg_wdata_i(cfg_wdata_i), .row_open_i(row_open_i),
   .supply_fault_i(supply_fault_i), .wr_ready_o(wr_ready_o),
   .refr_o(refr_o), .cfg_o(cfg_o), .sdram_cmd_o(sdram_cmd_o),
   .sdram_cke_o(sdram_cke_o), .self_refresh_o(self_refresh_o),
   .sleep_o(sleep_o));

// file: test/sdram_sleep_self_refresh_entry_bench.sv
// Self-checking bench for the sleep entry sequencer.
// Assumes the row model stands for the SDRAM on the far side.
`timescale 1ns/1ns
module sdram_sleep_self_refresh_entry_bench;
   logic mclk_i = 0, rst_n_i = 0, rw = 0, cw = 0, pw = 0, bf = 0, sf = 0;
   logic opq = 0, ro, bb, rdy, cke, sr, slp;
   logic [31:0] rd = 0, cd = 0, pd = 0, refr, cfg;
   logic [3:0] cmd;
   int err_total = 0, tests_run = 0, pre_cnt = 0;
   always #10 mclk_i = ~mclk_i;
   sdram_sleep_self_refresh_entry uut (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
      .refr_wr_i(rw), .refr_wdata_i(rd), .cfg_wr_i(cw), .cfg_wdata_i(cd),
      .pmc_wr_i(pw), .pmc_wdata_i(pd), .row_open_i(ro), .burst_busy_i(bb),
      .battery_fault_input_i(bf), .supply_fault_i(sf), .wr_ready_o(rdy),
      .refr_o(refr), .cfg_o(cfg), .sdram_cmd_o(cmd), .sdram_cke_o(cke),
      .self_refresh_o(sr), .sleep_o(slp));
   sdram_row_model mdl (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
      .open_req_i(opq), .sdram_cmd_i(cmd), .row_open_o(ro),
      .burst_busy_o(bb));
   always @(posedge mclk_i) if (cmd === 4'h2) pre_cnt <= pre_cnt + 1;
   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic idle(input int n);
      for (int i = 0; i < n && !(rdy === 1'b1); i++) @(negedge mclk_i);
      chk(rdy, 1'b1);
   endtask
   task automatic wr(input int k, input logic [31:0] d);
      idle(60);
      rw = (k == 0); cw = (k == 1); pw = (k == 2);
      rd = d; cd = d; pd = d;
      @(negedge mclk_i);
      rw = 0; cw = 0; pw = 0;
      @(negedge mclk_i);
      idle(60);
   endtask
   task automatic until_sleep(input logic v);
      for (int i = 0; i < 40 && slp !== v; i++) @(negedge mclk_i);
   endtask
   task automatic do_reset;
      rst_n_i = 0;
      repeat (10) @(negedge mclk_i);
      rst_n_i = 1;
      chk({rdy, cke, sr, slp, cmd}, {4'hc, 4'h7});
      chk(refr, 32'h0010_0000);
      chk(cfg, 32'h0000_0000);
   endtask
   // Steps two to five, with a burst running across step three
   task automatic prepare;
      int p0;
      wr(1, 32'h0003_1fff);
      wr(0, 32'h0010_0000);
      opq = 1;
      @(negedge mclk_i);
      opq = 0;
      p0 = pre_cnt;
      wr(0, 32'h8010_0000);
      chk(pre_cnt > p0, 1);
      chk({sr, cke, ro}, 3'h4);
      chk(refr, 32'h8010_0000);
      wr(1, 32'h0000_0000);
      chk(cfg, 32'h0000_0000);
      wr(0, 32'h0000_0000);
      chk({sr, cke}, 2'h2);
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic sc_software;
      do_reset();
      prepare();
      wr(2, 32'h0000_0001);
      until_sleep(1);
      chk(slp, 1);
   endtask
   task automatic sc_faults;
      do_reset();
      prepare();
      sf = 1;
      until_sleep(1);
      chk(slp, 1);
      sf = 0;
      until_sleep(0);
      chk(slp, 0);
      bf = 1;
      until_sleep(1);
      chk({slp, sr}, 2'h3);
      bf = 0;
   endtask
   // Fault rising during a burst, with no preparation at all
   task automatic sc_fault_burst;
      int p0;
      do_reset();
      p0 = pre_cnt;
      opq = 1;
      sf = 1;
      @(negedge mclk_i);
      opq = 0;
      until_sleep(1);
      chk(pre_cnt > p0, 1);
      chk({slp, sr, cke, ro}, 4'hc);
      sf = 0;
      until_sleep(0);
      chk(slp, 0);
   endtask
   task automatic report_and_stop;
      if (err_total == 0 && tests_run > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      #60000;
      err_total++;
      report_and_stop();
   end
   initial begin
      @(negedge mclk_i);
      sc_software();
      sc_faults();
      sc_fault_burst();
      report_and_stop();
   end
endmodule
